// File: logic/power_seq_regs.vh
/*
 Constants for the live-insertion power sequencer: clock rate, fixed
 qualification times, register offsets, reset values and status fields.
 Assumes inclusion by bare name from the sequencer design files.
*/
`ifndef POWER_SEQ_REGS_VH
`define POWER_SEQ_REGS_VH

// Clock rate
`define CLK_MHZ 20

// Fixed times in ns
`define T_EN_RESET_NS 10000
`define T_BRK_RESET_NS 120000
`define T_SLOW_NS 18000
`define T_FAST_NS 500

// Least times round up to whole cycles
`define CYC_CEIL(ns) (((ns) * `CLK_MHZ + 999) / 1000)
`define EN_RESET_CYC `CYC_CEIL(`T_EN_RESET_NS)
`define BRK_RESET_CYC `CYC_CEIL(`T_BRK_RESET_NS)
`define SLOW_CYC `CYC_CEIL(`T_SLOW_NS)
`define FAST_CYC `CYC_CEIL(`T_FAST_NS)

// Register word offsets (byte addresses)
`define REG_TIMER 12'h000
`define REG_TIMEOUT 12'h004
`define REG_FILTER 12'h008
`define REG_STATUS 12'h00c

// Register reset values and default discharge cycles
`define RST_TIMER 24'h002710
`define RST_TIMEOUT 24'h030d40
`define RST_FILTER 24'h000064
`define RST_DISCHARGE 24'h000014

// Status fields
`define ST_STATE_LSB 0
`define ST_STATE_MSB 5
`define ST_BREAKER 6
`define ST_PG_TIMING 7
`define ST_FILTER_EN 8
`define ST_EN_RESET 9
`define ST_LOCKOUT 10

`endif

// File: logic/sync_two_flop.v
/*
 Two-flop synchroniser for a bundle of independent level inputs.
 Assumes each bit is a slow level; no word coherence is implied.
*/
`timescale 1ns/1ps
module sync_two_flop #(
	parameter WIDTH = 1
) (
	input wire clk,
	input wire rst,
	input wire [WIDTH-1:0] din,
	output reg [WIDTH-1:0] dout
);
	reg [WIDTH-1:0] meta;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			meta <= {WIDTH{1'b0}};
			dout <= {WIDTH{1'b0}};
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule

// File: logic/level_qualifier.v
/*
 Counts consecutive cycles that a level stays high; flags once the count
 reaches the limit. Assumes a synchronous level and a limit of one or more.
*/
`timescale 1ns/1ps
module level_qualifier #(
	parameter CNT_W = 24
) (
	input wire clk,
	input wire rst,
	input wire level,
	input wire [CNT_W-1:0] limit,
	output wire done
);
	reg [CNT_W-1:0] cnt;

	// Saturates so a long-held level keeps the flag
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= {CNT_W{1'b0}};
		end else if (!level) begin
			cnt <= {CNT_W{1'b0}};
		end else if (cnt < limit) begin
			cnt <= cnt + 1'b1;
		end
	end

	assign done = level && (cnt >= limit);
endmodule

// File: logic/live_insertion_power_sequencer.v
/*
 Live-insertion power sequencer: lockout, enable reset, two timing
 cycles, soft-start, overcurrent breaker, power good timeout and filter,
 with an AHB-Lite register slave. Assumes comparator outputs arrive as
 asynchronous digital levels and one 20 MHz clock.
*/
// The AHB-Lite register port and the address map were left to the implementer.
// How it works
// - Enable low over 10 us resets all but breaker; gentle gate pulldown.
// - Breaker latch clears only after enable low continuously for 120 us.
// - Under lockout gate off; timer, timeout and filter nodes discharged.
// - First cycle starts with supply released, enable high and gate low.
// - First cycle ramps timer to threshold, then discharges it.
// - Second cycle starts only if fault line reads high; else stays off.
// - Second cycle start arms fast detector and enables soft-start control.
// - Soft-start raises or lowers gate as sense crosses its limit.
// - Second-cycle timer threshold ends soft-start, arms slow, enables pg.
// - After soft-start, gate pulled fully up by constant current source.
// - Power good enable releases timeout discharge and starts timeout timer.
// - Timeout expiry samples supply-ok, resets timer, enables glitch filter.
// - Supply-ok low at timeout trips the breaker latch.
// - Filter charges while supply-ok low; over threshold trips breaker.
// - Slow detector trips after sense above slow, below fast, over 18 us.
// - Fast detector trips after sense above fast for 500 ns or longer.
// - Trip clamps gate, latches fault low, resets pg, discharges nodes.
// - Enable high before 120 us keeps breaker latched, blocks new cycle.
// - Breaker reset releases fault pulldown so enable can recharge.
`timescale 1ns/1ps
`include "power_seq_regs.vh"
module live_insertion_power_sequencer #(
	parameter CNT_W = 24,
	parameter [CNT_W-1:0] DISCHARGE_CYCLES = `RST_DISCHARGE
) (
	// Clock and reset
	input wire CLK,
	input wire RST,
	// AHB-Lite slave
	input wire HSEL,
	input wire [31:0] HADDR,
	input wire [1:0] HTRANS,
	input wire HWRITE,
	input wire [2:0] HSIZE,
	input wire [31:0] HWDATA,
	input wire HREADY,
	output reg [31:0] HRDATA,
	output wire HREADYOUT,
	output wire HRESP,
	// Comparator and pin levels
	input wire SUPPLY_ABOVE_LOCKOUT,
	input wire EN_ABOVE_HIGH,
	input wire EN_BELOW_LOW,
	input wire GATE_BELOW_MIN,
	input wire FAULT_ABOVE_REF,
	input wire SENSE_ABOVE_SLOW,
	input wire SENSE_ABOVE_FAST,
	input wire SUPPLY_OK_INPUT,
	input wire FILTER_NODE_GROUNDED,
	// Gate drive
	output reg GATE_PULLUP,
	output reg GATE_PULLDOWN_SERVO,
	output reg GATE_PULLDOWN_GENTLE,
	output reg GATE_CLAMP,
	// Fault pin, open drain
	output wire FAULT_OUT,
	output reg FAULT_OE,
	// Node discharge switches
	output reg TIMER_DISCHARGE_SWITCH,
	output reg TIMEOUT_DISCHARGE_SWITCH,
	output reg FILTER_DISCHARGE_SWITCH
);
	localparam [5:0] S_IDLE = 6'h01;
	localparam [5:0] S_RAMP1 = 6'h02;
	localparam [5:0] S_DIS1 = 6'h04;
	localparam [5:0] S_CHECK = 6'h08;
	localparam [5:0] S_SOFT = 6'h10;
	localparam [5:0] S_ON = 6'h20;

	localparam integer EN_RESET_LIM = `EN_RESET_CYC;
	localparam integer BRK_RESET_LIM = `BRK_RESET_CYC;
	localparam integer SLOW_LIM = `SLOW_CYC;
	// Qualifier flags one cycle past its limit; 500 ns must already trip
	localparam integer FAST_LIM = `FAST_CYC - 1;

	wire [8:0] pins_sync;
	wire supply_ok;
	wire en_high;
	wire en_low;
	wire gate_low;
	wire fault_high;
	wire sense_slow;
	wire sense_fast;
	wire rails_ok;
	wire filter_grounded;

	reg [5:0] state;
	reg [CNT_W-1:0] tmr_cnt;
	reg [CNT_W-1:0] to_cnt;
	reg breaker_latch;
	reg pg_timing;
	reg filter_en;
	reg en_reset;
	reg [CNT_W-1:0] timer_cycles;
	reg [CNT_W-1:0] timeout_cycles;
	reg [CNT_W-1:0] filter_cycles;

	wire en_reset_done;
	wire brk_reset_done;
	wire slow_done;
	wire fast_done;
	wire filter_done;
	wire fast_trip;
	wire slow_trip;
	wire timeout_trip;
	wire filter_trip;
	wire trip;
	wire timeout_expired;

	// Every comparator crosses from the analog side
	sync_two_flop #(.WIDTH(9)) u_sync (
		.clk(CLK), .rst(RST), .dout(pins_sync),
		.din({SUPPLY_ABOVE_LOCKOUT, EN_ABOVE_HIGH, EN_BELOW_LOW,
			GATE_BELOW_MIN, FAULT_ABOVE_REF, SENSE_ABOVE_SLOW,
			SENSE_ABOVE_FAST, SUPPLY_OK_INPUT, FILTER_NODE_GROUNDED})
	);

	assign supply_ok = pins_sync[8];
	assign en_high = pins_sync[7];
	assign en_low = pins_sync[6];
	assign gate_low = pins_sync[5];
	assign fault_high = pins_sync[4];
	assign sense_slow = pins_sync[3];
	assign sense_fast = pins_sync[2];
	assign rails_ok = pins_sync[1];
	assign filter_grounded = pins_sync[0];

	level_qualifier #(.CNT_W(CNT_W)) u_en_reset (
		.clk(CLK), .rst(RST), .level(en_low),
		.limit(EN_RESET_LIM[CNT_W-1:0]), .done(en_reset_done)
	);

	level_qualifier #(.CNT_W(CNT_W)) u_brk_reset (
		.clk(CLK), .rst(RST), .level(en_low),
		.limit(BRK_RESET_LIM[CNT_W-1:0]), .done(brk_reset_done)
	);

	// Slow path only while below the fast threshold
	level_qualifier #(.CNT_W(CNT_W)) u_slow (
		.clk(CLK), .rst(RST), .level(sense_slow && !sense_fast),
		.limit(SLOW_LIM[CNT_W-1:0]), .done(slow_done)
	);

	level_qualifier #(.CNT_W(CNT_W)) u_fast (
		.clk(CLK), .rst(RST), .level(sense_fast),
		.limit(FAST_LIM[CNT_W-1:0]), .done(fast_done)
	);

	// A grounded filter node never charges
	level_qualifier #(.CNT_W(CNT_W)) u_filter (
		.clk(CLK), .rst(RST),
		.level(filter_en && !rails_ok && !filter_grounded),
		.limit(filter_cycles), .done(filter_done)
	);

	assign fast_trip = (state == S_SOFT || state == S_ON) && fast_done;
	assign slow_trip = (state == S_ON) && slow_done;
	assign timeout_expired = pg_timing && (to_cnt >= timeout_cycles);
	assign timeout_trip = timeout_expired && !rails_ok;
	assign filter_trip = filter_en && filter_done;
	assign trip = supply_ok &&
		(fast_trip || slow_trip || timeout_trip || filter_trip);

	// Breaker: a trip in the clearing cycle wins over the clear
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			breaker_latch <= 1'b0;
		end else if (trip) begin
			breaker_latch <= 1'b1;
		end else if (brk_reset_done) begin
			breaker_latch <= 1'b0;
		end
	end

	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			state <= S_IDLE;
			tmr_cnt <= {CNT_W{1'b0}};
			to_cnt <= {CNT_W{1'b0}};
			pg_timing <= 1'b0;
			filter_en <= 1'b0;
			en_reset <= 1'b0;
		end else if (!supply_ok || trip || en_reset_done) begin
			// Lockout, trip and enable reset all drop sequencing
			state <= S_IDLE;
			tmr_cnt <= {CNT_W{1'b0}};
			to_cnt <= {CNT_W{1'b0}};
			pg_timing <= 1'b0;
			filter_en <= 1'b0;
			en_reset <= supply_ok && !trip;
		end else begin
			case (state)
			S_IDLE: begin
				// Latched breaker blocks restart
				if (en_high && gate_low && !breaker_latch) begin
					state <= S_RAMP1;
					tmr_cnt <= {CNT_W{1'b0}};
					en_reset <= 1'b0;
				end
			end
			S_RAMP1: begin
				if (tmr_cnt >= timer_cycles) begin
					state <= S_DIS1;
					tmr_cnt <= {CNT_W{1'b0}};
				end else begin
					tmr_cnt <= tmr_cnt + 1'b1;
				end
			end
			S_DIS1: begin
				if (tmr_cnt >= DISCHARGE_CYCLES) begin
					state <= S_CHECK;
					tmr_cnt <= {CNT_W{1'b0}};
				end else begin
					tmr_cnt <= tmr_cnt + 1'b1;
				end
			end
			S_CHECK: begin
				// Held-low fault line keeps the switch off
				if (fault_high) begin
					state <= S_SOFT;
				end
			end
			S_SOFT: begin
				if (tmr_cnt >= timer_cycles) begin
					state <= S_ON;
					tmr_cnt <= {CNT_W{1'b0}};
					pg_timing <= 1'b1;
					to_cnt <= {CNT_W{1'b0}};
				end else begin
					tmr_cnt <= tmr_cnt + 1'b1;
				end
			end
			S_ON: begin
				if (timeout_expired) begin
					// Low sample already tripped above
					pg_timing <= 1'b0;
					to_cnt <= {CNT_W{1'b0}};
					filter_en <= 1'b1;
				end else if (pg_timing) begin
					to_cnt <= to_cnt + 1'b1;
				end
			end
			default: begin
				state <= S_IDLE;
			end
			endcase
		end
	end

	// Pin drive, registered one cycle behind the sequencer state
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			GATE_PULLUP <= 1'b0;
			GATE_PULLDOWN_SERVO <= 1'b0;
			GATE_PULLDOWN_GENTLE <= 1'b1;
			GATE_CLAMP <= 1'b0;
			FAULT_OE <= 1'b0;
			TIMER_DISCHARGE_SWITCH <= 1'b1;
			TIMEOUT_DISCHARGE_SWITCH <= 1'b1;
			FILTER_DISCHARGE_SWITCH <= 1'b1;
		end else begin
			GATE_CLAMP <= breaker_latch;
			FAULT_OE <= breaker_latch;
			GATE_PULLDOWN_GENTLE <= !supply_ok || en_reset;
			GATE_PULLUP <= !breaker_latch && supply_ok &&
				((state == S_SOFT && !sense_slow) ||
				state == S_ON);
			GATE_PULLDOWN_SERVO <= !breaker_latch && supply_ok &&
				state == S_SOFT && sense_slow;
			TIMER_DISCHARGE_SWITCH <= !supply_ok ||
				!(state == S_RAMP1 || state == S_SOFT);
			TIMEOUT_DISCHARGE_SWITCH <= !supply_ok || !pg_timing;
			FILTER_DISCHARGE_SWITCH <= !supply_ok ||
				!(filter_en && !rails_ok);
		end
	end

	// Open drain fault pin only ever pulls low
	assign FAULT_OUT = 1'b0;

	// AHB-Lite slave: zero wait states, always OKAY
	reg wr_pend;
	reg [11:0] wr_addr;
	wire take;
	wire in_map;
	wire [11:0] rd_addr;
	reg [31:0] rd_val;
	reg [31:0] status_word;

	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;
	assign take = HSEL && HTRANS[1] && HREADY;
	assign in_map = (HADDR[31:12] == 20'h00000);
	assign rd_addr = HADDR[11:0];

	always @* begin
		status_word = 32'h00000000;
		status_word[`ST_STATE_MSB:`ST_STATE_LSB] = state;
		status_word[`ST_BREAKER] = breaker_latch;
		status_word[`ST_PG_TIMING] = pg_timing;
		status_word[`ST_FILTER_EN] = filter_en;
		status_word[`ST_EN_RESET] = en_reset;
		status_word[`ST_LOCKOUT] = !supply_ok;
	end

	// Forward a pending write so back-to-back read sees it
	always @* begin
		rd_val = 32'h00000000;
		if (in_map) begin
			case (rd_addr)
			`REG_TIMER: rd_val[CNT_W-1:0] = timer_cycles;
			`REG_TIMEOUT: rd_val[CNT_W-1:0] = timeout_cycles;
			`REG_FILTER: rd_val[CNT_W-1:0] = filter_cycles;
			`REG_STATUS: rd_val = status_word;
			default: rd_val = 32'h00000000;
			endcase
			if (wr_pend && wr_addr == rd_addr &&
				(rd_addr == `REG_TIMER || rd_addr == `REG_TIMEOUT ||
				rd_addr == `REG_FILTER)) begin
				rd_val = {{(32-CNT_W){1'b0}}, HWDATA[CNT_W-1:0]};
			end
		end
	end

	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			wr_pend <= 1'b0;
			wr_addr <= 12'h000;
			HRDATA <= 32'h00000000;
		end else begin
			wr_pend <= take && HWRITE && in_map;
			if (take) begin
				wr_addr <= rd_addr;
			end
			if (take && !HWRITE) begin
				HRDATA <= rd_val;
			end
		end
	end

	// Software programs the capacitor-set delays
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			timer_cycles <= `RST_TIMER;
			timeout_cycles <= `RST_TIMEOUT;
			filter_cycles <= `RST_FILTER;
		end else if (wr_pend) begin
			case (wr_addr)
			`REG_TIMER: timer_cycles <= HWDATA[CNT_W-1:0];
			`REG_TIMEOUT: timeout_cycles <= HWDATA[CNT_W-1:0];
			`REG_FILTER: filter_cycles <= HWDATA[CNT_W-1:0];
			default: timer_cycles <= timer_cycles;
			endcase
		end
	end
endmodule

// File: dv/power_seq_asserts.sv
/*
 Checker for the power sequencer top ports.
 Assumes a bind to the sequencer; all signals in one clock domain.
*/
`timescale 1ns/1ps
module power_seq_asserts (
	// Clock and reset
	input wire CLK,
	input wire RST,
	// Levels in
	input wire SUPPLY_ABOVE_LOCKOUT,
	input wire EN_BELOW_LOW,
	input wire FAULT_ABOVE_REF,
	// Drive out
	input wire GATE_PULLUP,
	input wire GATE_PULLDOWN_SERVO,
	input wire GATE_PULLDOWN_GENTLE,
	input wire GATE_CLAMP,
	input wire FAULT_OE,
	input wire TIMER_DISCHARGE_SWITCH,
	input wire TIMEOUT_DISCHARGE_SWITCH,
	input wire FILTER_DISCHARGE_SWITCH
);
	logic [11:0] en_low_cnt;
	// Saturates so a long hold never wraps back under the limits
	always @(posedge CLK or posedge RST) begin
		if (RST)
			en_low_cnt <= 12'h000;
		else if (!EN_BELOW_LOW)
			en_low_cnt <= 12'h000;
		else if (en_low_cnt != 12'hfff)
			en_low_cnt <= en_low_cnt + 12'h001;
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	a_lockout_hold: assert property (
		!SUPPLY_ABOVE_LOCKOUT [*5] |-> !GATE_PULLUP && TIMER_DISCHARGE_SWITCH
		&& TIMEOUT_DISCHARGE_SWITCH && FILTER_DISCHARGE_SWITCH)
		else $error("lockout outputs wrong");
	a_enable_reset: assert property (
		en_low_cnt >= 12'd210 |-> GATE_PULLDOWN_GENTLE && !GATE_PULLUP)
		else $error("enable reset missing");
	a_breaker_clear: assert property (
		($fell(FAULT_OE) |-> en_low_cnt >= 12'd2400)
		and (en_low_cnt == 12'd2410 |-> !FAULT_OE))
		else $error("breaker cleared at wrong time");
	a_breaker_hold: assert property (
		FAULT_OE && en_low_cnt < 12'd2000 |=> FAULT_OE)
		else $error("breaker released early");
	a_trip_outputs: assert property (
		$rose(FAULT_OE) |-> GATE_CLAMP && !GATE_PULLUP && !GATE_PULLDOWN_SERVO
		&& TIMEOUT_DISCHARGE_SWITCH && FILTER_DISCHARGE_SWITCH)
		else $error("trip outputs wrong");
	a_gate_excl: assert property (
		GATE_PULLUP |-> !GATE_PULLDOWN_SERVO && !GATE_CLAMP
		&& !GATE_PULLDOWN_GENTLE)
		else $error("gate drives overlap");
	a_timeout_release: assert property (
		$fell(TIMEOUT_DISCHARGE_SWITCH) |-> GATE_PULLUP)
		else $error("timeout released outside on");
	a_fault_blocks: assert property (
		!FAULT_ABOVE_REF [*8] |-> !GATE_PULLUP)
		else $error("gate up with fault low");
endmodule
bind live_insertion_power_sequencer power_seq_asserts u_asserts (.*);

// File: dv/power_seq_far_side.sv
/*
 Far-side model: supply, enable network, pass transistor gate, sense
 resistor, fault pin pull-up and supply monitor. Assumes bench controls.
*/
`timescale 1ns/1ps
module power_seq_far_side (
	// Clock
	input wire CLK,
	// Bench controls
	input wire supply,
	input wire en,
	input wire [1:0] sense,
	input wire pg_ok,
	input wire fhold,
	input wire fgnd,
	input wire retry,
	// From the sequencer
	input wire GATE_PULLUP,
	input wire GATE_CLAMP,
	input wire GATE_PULLDOWN_GENTLE,
	input wire FAULT_OE,
	// Comparator levels
	output wire SUPPLY_ABOVE_LOCKOUT,
	output wire EN_ABOVE_HIGH,
	output wire EN_BELOW_LOW,
	output wire GATE_BELOW_MIN,
	output wire FAULT_ABOVE_REF,
	output wire SENSE_ABOVE_SLOW,
	output wire SENSE_ABOVE_FAST,
	output wire SUPPLY_OK_INPUT,
	output wire FILTER_NODE_GROUNDED
);
	logic gate_up = 1'b0;
	always @(posedge CLK) begin
		if (GATE_CLAMP || GATE_PULLDOWN_GENTLE)
			gate_up <= 1'b0;
		else if (GATE_PULLUP)
			gate_up <= 1'b1;
	end
	// Autoretry wiring: a latched fault pin drags the enable node low
	wire en_pin = en && !(retry && FAULT_OE);
	assign SUPPLY_ABOVE_LOCKOUT = supply;
	assign EN_ABOVE_HIGH = en_pin;
	assign EN_BELOW_LOW = !en_pin;
	assign GATE_BELOW_MIN = !gate_up;
	// Pin has a pull-up; bench may hold it low
	assign FAULT_ABOVE_REF = !FAULT_OE && !fhold;
	assign SENSE_ABOVE_SLOW = sense != 2'b00;
	assign SENSE_ABOVE_FAST = sense[1];
	assign SUPPLY_OK_INPUT = pg_ok;
	assign FILTER_NODE_GROUNDED = fgnd;
endmodule

// File: dv/live_insertion_power_sequencer_tb.sv
/*
 Testbench: registers, power-up, trips and breaker reset of the sequencer.
 Assumes the far-side model and the bound checker.
*/
`timescale 1ns/1ps
`include "power_seq_regs.vh"
module live_insertion_power_sequencer_tb;
	logic CLK = 1'b0;
	logic RST = 1'b1;
	logic HSEL = 1'b0, HWRITE = 1'b0;
	logic [1:0] HTRANS = 2'b00;
	logic [2:0] HSIZE = 3'h2;
	logic [31:0] HADDR = 32'h0, HWDATA = 32'h0;
	logic supply = 1'b0, en = 1'b0, pg_ok = 1'b0, fhold = 1'b0, fgnd = 1'b0;
	logic [1:0] sense = 2'b00;
	logic retry = 1'b0;
	wire [31:0] HRDATA;
	wire HREADYOUT, HRESP, HREADY, FAULT_OUT, FAULT_OE, GATE_CLAMP;
	wire GATE_PULLUP, GATE_PULLDOWN_SERVO, GATE_PULLDOWN_GENTLE;
	wire TIMER_DISCHARGE_SWITCH, TIMEOUT_DISCHARGE_SWITCH;
	wire FILTER_DISCHARGE_SWITCH, SUPPLY_ABOVE_LOCKOUT, EN_ABOVE_HIGH;
	wire EN_BELOW_LOW, GATE_BELOW_MIN, FAULT_ABOVE_REF, SENSE_ABOVE_SLOW;
	wire SENSE_ABOVE_FAST, SUPPLY_OK_INPUT, FILTER_NODE_GROUNDED;
	int error_cnt = 0, num_checks = 0;
	assign HREADY = HREADYOUT;
	always #25 CLK = ~CLK;
	live_insertion_power_sequencer #(.DISCHARGE_CYCLES(24'h000002)) u_dut (.*);
	power_seq_far_side u_far (.*);

	task chk(input string nm, input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task bus(input logic w, input logic [31:0] a, d, output logic [31:0] q);
		@(posedge CLK);
		HSEL <= 1'b1; HTRANS <= 2'b10; HADDR <= a; HWRITE <= w;
		do @(posedge CLK); while (HREADY !== 1'b1);
		HSEL <= 1'b0; HTRANS <= 2'b00; HWDATA <= d;
		do @(posedge CLK); while (HREADY !== 1'b1);
		q = HRDATA;
		chk("resp", {HREADYOUT, HRESP}, 2'b10);
	endtask
	task wr(input logic [31:0] a, d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task rd(input logic [31:0] a, output logic [31:0] q);
		bus(1'b0, a, 32'h0, q);
	endtask
	task wst(input logic [10:0] m, v);
		logic [31:0] q;
		q = 32'h0;
		for (int i = 0; i < 3000 && (q[10:0] & m) !== v; i++)
			rd(`REG_STATUS, q);
		chk("status", q[10:0] & m, v);
	endtask
	// Low pulse on supply-ok, or a sense level, then let it settle
	task pulse(input logic pg, input logic [1:0] s, input int n);
		@(posedge CLK);
		if (pg) pg_ok <= 1'b0; else sense <= s;
		repeat (n) @(posedge CLK);
		pg_ok <= 1'b1; sense <= 2'b00;
		repeat (6) @(posedge CLK);
	endtask
	task trip(input logic e);
		logic [31:0] q;
		rd(`REG_STATUS, q);
		chk("breaker", {q[`ST_BREAKER], FAULT_OE, GATE_CLAMP}, {3{e}});
		chk("fault pin", FAULT_OUT, 1'b0);
	endtask
	task give_verdict;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		logic [31:0] q, v;
		v = $urandom(85626);
		repeat (12) @(posedge CLK);
		RST <= 1'b0;
		repeat (8) @(posedge CLK);
		chk("lockout", {GATE_PULLDOWN_GENTLE, TIMER_DISCHARGE_SWITCH,
			TIMEOUT_DISCHARGE_SWITCH, FILTER_DISCHARGE_SWITCH,
			GATE_PULLUP}, 5'b11110);
		rd(`REG_TIMER, q); chk("timer", q, {8'h00, `RST_TIMER});
		rd(`REG_TIMEOUT, q); chk("tmo", q, {8'h00, `RST_TIMEOUT});
		rd(`REG_FILTER, q); chk("filter", q, {8'h00, `RST_FILTER});
		wr(32'h010, 32'hffffffff); rd(32'h010, q); chk("unmapped", q, 0);
		v = $urandom; wr(`REG_FILTER, v); rd(`REG_FILTER, q);
		chk("filter rw", q, {8'h00, v[23:0]});
		wr(`REG_TIMER, 32'd60 + $urandom % 8);
		wr(`REG_TIMEOUT, 32'd20);
		wr(`REG_FILTER, 32'd3);
		rd(`REG_STATUS, q); chk("lockout bit", q[`ST_LOCKOUT], 1'b1);
		fhold <= 1'b1; supply <= 1'b1; en <= 1'b1; pg_ok <= 1'b1;
		wst(11'h03f, 11'h008);
		repeat (30) @(posedge CLK);
		rd(`REG_STATUS, q); chk("held", {q[5:0], GATE_PULLUP}, 7'h10);
		fhold <= 1'b0;
		wst(11'h03f, 11'h010);
		sense <= 2'b01; repeat (5) @(posedge CLK);
		chk("servo dn", {GATE_PULLDOWN_SERVO, GATE_PULLUP}, 2'b10);
		chk("timer ramp", TIMER_DISCHARGE_SWITCH, 1'b0);
		sense <= 2'b00; repeat (5) @(posedge CLK);
		chk("servo up", {GATE_PULLDOWN_SERVO, GATE_PULLUP}, 2'b01);
		wst(11'h03f, 11'h020);
		rd(`REG_STATUS, q);
		chk("on", {GATE_PULLUP, TIMEOUT_DISCHARGE_SWITCH,
			q[`ST_PG_TIMING]}, 3'b101);
		wst(11'h180, 11'h100);
		chk("tmo dis", TIMEOUT_DISCHARGE_SWITCH, 1'b1);
		fgnd <= 1'b1; pg_ok <= 1'b0; repeat (20) @(posedge CLK);
		pg_ok <= 1'b1; fgnd <= 1'b0; repeat (6) @(posedge CLK);
		trip(1'b0);
		pulse(1'b1, 2'b00, 2); trip(1'b0);
		pulse(1'b1, 2'b00, 6); trip(1'b1);
		en <= 1'b0; repeat (1000) @(posedge CLK);
		chk("gentle", GATE_PULLDOWN_GENTLE, 1'b1);
		en <= 1'b1; repeat (40) @(posedge CLK);
		rd(`REG_STATUS, q); chk("no restart", q[6:0], 7'h41);
		// Fast in soft-start, slow when on, supply-ok low at timeout
		for (int k = 0; k < 3; k++) begin
			en <= 1'b0; repeat (2450) @(posedge CLK);
			trip(1'b0);
			en <= 1'b1; pg_ok <= (k != 2);
			if (k == 0) begin
				wst(11'h03f, 11'h010);
				pulse(1'b0, 2'b11, 9); trip(1'b0);
				pulse(1'b0, 2'b11, 10 + $urandom % 3); trip(1'b1);
			end else begin
				wst(11'h03f, 11'h020);
				if (k == 1) begin
					pulse(1'b0, 2'b01, 355); trip(1'b0);
					pulse(1'b0, 2'b01, 365); trip(1'b1);
				end else begin
					repeat (40) @(posedge CLK);
					trip(1'b1);
				end
			end
		end
		// Autoretry: latched fault pin holds enable low until breaker clears
		pg_ok <= 1'b1;
		retry <= 1'b1;
		wst(11'h07f, 11'h020);
		trip(1'b0);
		give_verdict;
	end
	initial begin
		repeat (60000) @(posedge CLK);
		error_cnt++;
		give_verdict;
	end
endmodule
